// ### verification/extra_param_block_bench.sv
// bench for the extra parameter block: window accesses and decoder events
// needs host_model; the checker binds itself to the block
`timescale 1ns/1ps
`include "xparam_map.svh"

module extra_param_block_bench;
  logic clk_sys, rst, file_start, header_done, frame_decoded, stream_byte, seek_upd;
  logic pos_known, stream_error, resync_found, pkt_len_upd, clk_too_slow, aac_start;
  logic elem_auto_sel, midi_track_load, midi_byte_step, vorbis_hdr, vorbis_tag_found;
  logic [2:0] seek_upd_idx;
  logic [3:0] clk_step_max, bandrep_status, reverb, clk_step;
  logic [15:0] fill_byte_value, sce_found, cpe_found, lfe_found, elem_auto_value;
  logic [15:0] vorbis_tag_gain, time_step, elem_choice, drc_cut, drc_lift, stream_info_lo;
  logic [31:0] seek_upd_offset, pos_ms, pkt_cur_len, pkt_hdr_len, midi_track_len, v;
  logic frame_play, streaming_mode, wav_ignore_sizes, seek_blocked, decode_give_up;
  logic stream_info_lo_upd, ok;
  logic [1:0] ps_mode, sbr_mode;
  xparam_pkg::codec_t active_codec;
  xparam_pkg::win_req_t win_req;
  xparam_pkg::win_rsp_t win_rsp;
  int n_mismatch, checks, n;

  // short refresh period keeps the byte rate scenario brief
  extra_param_block #(.REFRESH_CYCLES(20)) dut (.clk_sys, .rst, .win_req, .win_rsp,
    .active_codec, .file_start, .header_done, .frame_decoded, .stream_byte,
    .fill_byte_value, .seek_upd, .seek_upd_idx, .seek_upd_offset, .pos_known, .pos_ms,
    .stream_error, .resync_found, .pkt_len_upd, .pkt_cur_len, .pkt_hdr_len, .clk_too_slow,
    .clk_step_max, .aac_start, .sce_found, .cpe_found, .lfe_found, .elem_auto_sel,
    .elem_auto_value, .bandrep_status, .midi_track_load, .midi_track_len, .midi_byte_step,
    .vorbis_hdr, .vorbis_tag_found, .vorbis_tag_gain, .frame_play, .time_step, .ps_mode,
    .sbr_mode, .reverb, .streaming_mode, .wav_ignore_sizes, .seek_blocked, .decode_give_up,
    .clk_step, .elem_choice, .drc_cut, .drc_lift, .stream_info_lo_upd, .stream_info_lo);
  host_model host (.clk_sys, .win_req, .win_rsp);

  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic bound(input bit hit);
    if (!hit)
    begin
      chk(32'h0, 32'h1);
      complete_run();
    end
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] e, input bit two = 0);
    host.rd(a, two, v, ok);
    bound(ok === 1'b1);
    chk(v, e);
  endtask

  task automatic pulse(ref logic s);
    @(negedge clk_sys);
    s = 1'b1;
    @(negedge clk_sys);
    s = 1'b0;
  endtask

  initial
  begin
    {file_start, header_done, frame_decoded, stream_byte, seek_upd, pos_known, stream_error,
      resync_found, pkt_len_upd, clk_too_slow, aac_start, elem_auto_sel, midi_track_load,
      midi_byte_step, vorbis_hdr, vorbis_tag_found, seek_upd_idx, clk_step_max,
      bandrep_status, fill_byte_value, sce_found, cpe_found, lfe_found, elem_auto_value,
      vorbis_tag_gain, seek_upd_offset, pos_ms, pkt_cur_len, pkt_hdr_len,
      midi_track_len} = '0;
    active_codec = xparam_pkg::CODEC_NONE;
    rst = 1'b1;
    repeat (10) @(negedge clk_sys);
    rst = 1'b0;
    chk(seek_blocked, 1);
    rd(`XP_LAYOUT_REV_ADDR, 32'h3);
    host.wr(`XP_LAYOUT_REV_ADDR, 16'h00ff);
    rd(`XP_LAYOUT_REV_ADDR, 32'h3);
    rd(`XP_RESYNC_ADDR, 32'h7fff);
    rd(`XP_PLAY_POS_ADDR, 32'hffffffff, 1);
    rd(16'h1e10, 32'h0);
    pulse(header_done);
    chk(seek_blocked, 0);
    host.wr(`XP_MISC_CFG_ADDR, 16'hffe6);
    chk({ps_mode, sbr_mode, reverb}, 32'he6);
    host.wr(`XP_FF_FACTOR_ADDR, 16'h0003);
    pulse(file_start);
    chk(seek_blocked, 1);
    rd(`XP_MISC_CFG_ADDR, 32'h00e6);
    chk(time_step, 32'h3);
    for (n = 0; n < 4; n++)
    begin
      @(negedge clk_sys);
      frame_decoded = 1'b1;
      #1 chk(frame_play, (n % 3) == 0);
    end
    @(negedge clk_sys);
    frame_decoded = 1'b0;
    host.wr(`XP_FF_FACTOR_ADDR, 16'h0000);
    chk(time_step, 32'h1);
    // one byte per cycle gives a rate equal to the refresh period
    fill_byte_value = 16'h00a5;
    active_codec = xparam_pkg::CODEC_AAC;
    stream_byte = 1'b1;
    repeat (45) @(negedge clk_sys);
    for (n = 0; n < 30 && stream_info_lo_upd !== 1'b1; n++)
      @(negedge clk_sys);
    bound(n < 30);
    chk(stream_info_lo, 32'd20);
    rd(`XP_BYTE_RATE_ADDR, 32'd20);
    rd(`XP_END_FILL_ADDR, 32'h00a5);
    active_codec = xparam_pkg::CODEC_MPEG;
    v = 0;
    repeat (30)
    begin
      @(negedge clk_sys);
      v = v + stream_info_lo_upd;
    end
    chk(v, 32'h0);
    stream_byte = 1'b0;
    seek_upd_idx = 3'd5;
    seek_upd_offset = 32'h12345678;
    pulse(seek_upd);
    rd(`XP_LAST_SEEK_ADDR, 32'h5);
    rd(`XP_SEEK_TABLE_ADDR + 16'd10, 32'h5678);
    rd(`XP_SEEK_TABLE_ADDR + 16'd10, 32'h12345678, 1);
    pos_known = 1'b1;
    pos_ms = 32'h00010002;
    rd(`XP_PLAY_POS_ADDR, 32'h00010002, 1);
    host.wr(`XP_RESYNC_ADDR, 16'h0000);
    chk({streaming_mode, wav_ignore_sizes}, 32'h0);
    pulse(stream_error);
    chk(decode_give_up, 1);
    host.wr(`XP_RESYNC_ADDR, 16'h0002);
    pulse(file_start);
    chk({decode_give_up, streaming_mode, wav_ignore_sizes}, 32'h3);
    repeat (2) pulse(stream_error);
    chk(decode_give_up, 0);
    pulse(stream_error);
    chk(decode_give_up, 1);
    host.wr(`XP_RESYNC_ADDR, `XP_RESYNC_UNLIMITED);
    pulse(file_start);
    repeat (4) pulse(stream_error);
    chk(decode_give_up, 0);
    // a found sync point restarts the retry count
    host.wr(`XP_RESYNC_ADDR, 16'h0001);
    pulse(resync_found);
    pulse(stream_error);
    chk(decode_give_up, 0);
    pulse(stream_error);
    chk(decode_give_up, 1);
    active_codec = xparam_pkg::CODEC_AAC;
    host.wr(`XP_DRC_CUT_ADDR, 16'h1234);
    host.wr(`XP_OVL3_ADDR, 16'h0015);
    rd(`XP_DRC_CUT_ADDR, 32'h1234);
    pulse(aac_start);
    chk({elem_choice, drc_cut}, 32'h0000e000);
    chk(drc_lift, 32'h2000);
    elem_auto_value = 16'h0025;
    pulse(elem_auto_sel);
    rd(`XP_OVL3_ADDR, 32'h25);
    @(negedge clk_sys);
    sce_found = 16'h0001;
    cpe_found = 16'h0002;
    @(negedge clk_sys);
    sce_found = 16'h0002;
    cpe_found = 16'h0000;
    @(negedge clk_sys);
    sce_found = 16'h0000;
    rd(`XP_OVL0_ADDR, 32'h3);
    rd(`XP_OVL1_ADDR, 32'h2);
    host.wr(`XP_OVL0_ADDR, 16'h0000);
    rd(`XP_OVL0_ADDR, 32'h0);
    for (n = 0; n < 4; n++)
    begin
      bandrep_status = 4'h1 << n;
      rd(`XP_BANDREP_ADDR, 32'h1 << n);
    end
    active_codec = xparam_pkg::CODEC_VORBIS;
    pulse(vorbis_hdr);
    host.wr(`XP_OVL0_ADDR, 16'h0007);
    rd(`XP_OVL0_ADDR, 32'hfff4);
    vorbis_tag_found = 1'b1;
    vorbis_tag_gain = 16'h0005;
    pulse(vorbis_hdr);
    rd(`XP_OVL0_ADDR, 32'h5);
    active_codec = xparam_pkg::CODEC_MIDI;
    midi_track_len = 32'h00010000;
    pulse(midi_track_load);
    pulse(midi_byte_step);
    rd(`XP_OVL0_ADDR, 32'h0000ffff, 1);
    active_codec = xparam_pkg::CODEC_PACKET;
    clk_step_max = 4'd2;
    pkt_cur_len = 32'h00000100;
    pkt_hdr_len = 32'h00000200;
    pulse(pkt_len_upd);
    rd(`XP_OVL0_ADDR, 32'h100, 1);
    rd(`XP_OVL2_ADDR, 32'h200, 1);
    repeat (3) pulse(clk_too_slow);
    chk(clk_step, 32'h2);
    pulse(file_start);
    chk(clk_step, 32'h0);
    complete_run();
  end
endmodule

// ### verification/extra_param_block_properties.sv
// port checker for the extra parameter block
// bound to every extra_param_block; one clock domain
`timescale 1ns/1ps
`include "xparam_map.svh"

module extra_param_block_properties (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // ram window
  input wire xparam_pkg::win_req_t win_req,
  input wire xparam_pkg::win_rsp_t win_rsp,
  // decoder side
  input wire xparam_pkg::codec_t active_codec,
  input wire logic file_start,
  input wire logic header_done,
  input wire logic stream_error,
  input wire logic aac_start,
  input wire logic clk_too_slow,
  input wire logic [3:0] clk_step_max,
  input wire logic [15:0] time_step,
  input wire logic [1:0] ps_mode,
  input wire logic [1:0] sbr_mode,
  input wire logic [3:0] reverb,
  input wire logic streaming_mode,
  input wire logic wav_ignore_sizes,
  input wire logic seek_blocked,
  input wire logic decode_give_up,
  input wire logic [3:0] clk_step,
  input wire logic [15:0] elem_choice,
  input wire logic [15:0] drc_cut,
  input wire logic [15:0] drc_lift
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence rev_req;
    win_req.rd && win_req.addr == `XP_LAYOUT_REV_ADDR;
  endsequence
  sequence rev_ans;
    win_rsp.valid && win_rsp.data == 16'h0003;
  endsequence

  chk_rev_answer: assert property (rev_req |=> rev_ans)
    else $error("layout revision read wrong");
  chk_cfg_fields: assert property ((win_req.wr && win_req.addr == `XP_MISC_CFG_ADDR)
    |=> {ps_mode, sbr_mode, reverb} == $past(win_req.wdata[7:0]))
    else $error("misc config fields wrong");
  chk_ff_step: assert property ((win_req.wr && win_req.addr == `XP_FF_FACTOR_ADDR)
    |=> time_step == ($past(win_req.wdata) > 16'h0001 ? $past(win_req.wdata) : 16'h0001))
    else $error("fast forward step wrong");
  chk_file_keep: assert property (file_start && !win_req.wr
    |=> $stable({ps_mode, sbr_mode, reverb, time_step}))
    else $error("config lost at file start");
  chk_stream_mode: assert property ((win_req.wr && win_req.addr == `XP_RESYNC_ADDR)
    |=> streaming_mode == ($past(win_req.wdata) != 16'h0000) && wav_ignore_sizes == streaming_mode)
    else $error("streaming mode wrong");
  chk_reset_vals: assert property ($past(rst) |-> streaming_mode && seek_blocked
    && drc_cut == 16'he000 && drc_lift == 16'h2000 && time_step == 16'h0001)
    else $error("reset values wrong");
  chk_aac_init: assert property ((aac_start && active_codec == xparam_pkg::CODEC_AAC)
    |=> elem_choice == 16'h0000 && drc_cut == 16'he000 && drc_lift == 16'h2000)
    else $error("aac start init wrong");
  chk_seek_hold: assert property ((file_start || (seek_blocked && !header_done))
    |=> seek_blocked)
    else $error("seek block dropped early");
  chk_seek_free: assert property ((header_done && !file_start) |=> !seek_blocked)
    else $error("seek block not cleared");
  chk_give_up: assert property ((stream_error && !streaming_mode && !file_start)
    |=> decode_give_up)
    else $error("no stop at first error");
  chk_clk_cap: assert property ((clk_too_slow && active_codec == xparam_pkg::CODEC_PACKET
    && !file_start) |=> clk_step == ($past(clk_step) < $past(clk_step_max) ?
    $past(clk_step) + 4'h1 : $past(clk_step_max)))
    else $error("clock step wrong");
endmodule

bind extra_param_block extra_param_block_properties chk_i (.clk_sys, .rst, .win_req,
  .win_rsp, .active_codec, .file_start, .header_done, .stream_error, .aac_start,
  .clk_too_slow, .clk_step_max, .time_step, .ps_mode, .sbr_mode, .reverb, .streaming_mode,
  .wav_ignore_sizes, .seek_blocked, .decode_give_up, .clk_step, .elem_choice, .drc_cut,
  .drc_lift);

// ### verification/host_model.sv
// host model: drives ram window reads and writes, takes the answers
// waits up to four cycles for the block to answer a read, else flags it
`timescale 1ns/1ps

module host_model (
  // clock
  input wire logic clk_sys,
  // ram window
  output xparam_pkg::win_req_t win_req,
  input wire xparam_pkg::win_rsp_t win_rsp
);
  initial win_req = '0;

  // idle lines show the inverse of the last value, never a stale copy
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    win_req = '{1'b0, 1'b1, a, d};
    @(negedge clk_sys);
    win_req = '{1'b0, 1'b0, ~a, ~d};
  endtask

  task automatic rd1(input logic [15:0] a, output logic [15:0] d, inout logic ok);
    int i;
    @(negedge clk_sys);
    win_req.rd = 1'b1;
    win_req.addr = a;
    for (i = 0; i < 4; i++)
    begin
      @(negedge clk_sys);
      win_req.rd = 1'b0;
      win_req.addr = ~a;
      if (win_rsp.valid === 1'b1)
        break;
    end
    d = win_rsp.data;
    ok = ok && (i < 4);
  endtask

  // two-word values are read twice; the second pair wins on a torn read
  task automatic rd(input logic [15:0] a, input bit two, output logic [31:0] v,
    output logic ok);
    logic [15:0] w [4];
    int k;
    ok = 1'b1;
    for (k = 0; k < (two ? 4 : 1); k++)
      rd1(a + 16'(k % 2), w[k], ok);
    v = two ? {w[3], w[2]} : {16'h0000, w[0]};
  endtask
endmodule

// ### verilog/byte_rate_meter.sv
// byte rate meter: counts stream bytes and latches the count once per period
// assumes byte_in pulses come from decoder logic on clk_sys
`timescale 1ns/1ps
`include "xparam_map.svh"

module byte_rate_meter #(
  parameter int unsigned PERIOD_CYCLES = `XP_REFRESH_CYCLES
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // stream side
  input wire logic byte_in,
  // result
  output logic [15:0] rate,
  output logic tick
);

  xparam_pkg::meter_state_t st_r;
  xparam_pkg::meter_state_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (st_r.cycle_cnt == 32'(PERIOD_CYCLES - 1))
    begin
      st_nxt.cycle_cnt = 32'h0;
      // a byte in the closing cycle still counts toward this period
      st_nxt.byte_cnt = 32'h0;
      st_nxt.rate = (st_r.byte_cnt + {31'h0, byte_in}) > 32'h0000ffff ?
        16'hffff : 16'(st_r.byte_cnt + {31'h0, byte_in});
      st_nxt.tick = 1'b1;
    end
    else
    begin
      st_nxt.cycle_cnt = st_r.cycle_cnt + 32'h1;
      st_nxt.byte_cnt = st_r.byte_cnt + {31'h0, byte_in};
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign rate = st_r.rate;
  assign tick = st_r.tick;

endmodule

// ### verilog/extra_param_block.sv
// extra parameter block of the decoder data memory, reached by the host
// through the ram window pointer / ram window data pair.
// assumes all decoder-side event inputs are one-cycle pulses on clk_sys
`timescale 1ns/1ps
`include "xparam_map.svh"

module extra_param_block #(
  parameter int unsigned REFRESH_CYCLES = `XP_REFRESH_CYCLES
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // ram window access from the serial control interface
  input wire xparam_pkg::win_req_t win_req,
  output xparam_pkg::win_rsp_t win_rsp,
  // decoder status
  input wire xparam_pkg::codec_t active_codec,
  input wire logic file_start,
  input wire logic header_done,
  input wire logic frame_decoded,
  input wire logic stream_byte,
  input wire logic [15:0] fill_byte_value,
  // seek table updates
  input wire logic seek_upd,
  input wire logic [2:0] seek_upd_idx,
  input wire logic [31:0] seek_upd_offset,
  // play position
  input wire logic pos_known,
  input wire logic [31:0] pos_ms,
  // error recovery
  input wire logic stream_error,
  input wire logic resync_found,
  // packet codec
  input wire logic pkt_len_upd,
  input wire logic [31:0] pkt_cur_len,
  input wire logic [31:0] pkt_hdr_len,
  input wire logic clk_too_slow,
  input wire logic [3:0] clk_step_max,
  // AAC
  input wire logic aac_start,
  input wire logic [15:0] sce_found,
  input wire logic [15:0] cpe_found,
  input wire logic [15:0] lfe_found,
  input wire logic elem_auto_sel,
  input wire logic [15:0] elem_auto_value,
  input wire logic [3:0] bandrep_status,
  // MIDI
  input wire logic midi_track_load,
  input wire logic [31:0] midi_track_len,
  input wire logic midi_byte_step,
  // Vorbis
  input wire logic vorbis_hdr,
  input wire logic vorbis_tag_found,
  input wire logic [15:0] vorbis_tag_gain,
  // decoder control
  output logic frame_play,
  output logic [15:0] time_step,
  output logic [1:0] ps_mode,
  output logic [1:0] sbr_mode,
  output logic [3:0] reverb,
  output logic streaming_mode,
  output logic wav_ignore_sizes,
  output logic seek_blocked,
  output logic decode_give_up,
  output logic [3:0] clk_step,
  output logic [15:0] elem_choice,
  output logic [15:0] drc_cut,
  output logic [15:0] drc_lift,
  // stream info low mirror
  output logic stream_info_lo_upd,
  output logic [15:0] stream_info_lo
);

  xparam_pkg::xstate_t st_r;
  xparam_pkg::xstate_t st_nxt;
  logic [15:0] rate;
  logic rate_tick;
  logic [15:0] info_lo_r;
  logic info_upd_r;

  byte_rate_meter #(
    .PERIOD_CYCLES(REFRESH_CYCLES)
  ) u_meter (
    .clk_sys(clk_sys),
    .rst(rst),
    .byte_in(stream_byte),
    .rate(rate),
    .tick(rate_tick)
  );

  // true when a window write hits the given word
  function automatic logic wr_hit(input xparam_pkg::win_req_t r, input logic [15:0] a);
    wr_hit = r.wr && (r.addr == a);
  endfunction

  // high or low half of a two-word value by address parity against its base
  function automatic logic [15:0] half(input logic [31:0] v, input logic hi);
    half = hi ? v[31:16] : v[15:0];
  endfunction

  function automatic logic [15:0] read_word(input xparam_pkg::xstate_t s,
                                            input logic [15:0] a,
                                            input logic [15:0] rt,
                                            input logic pk,
                                            input logic [31:0] pm,
                                            input xparam_pkg::codec_t c);
    logic [15:0] d;
    logic [15:0] rel;
    logic [31:0] pos;
    d = 16'h0000;
    rel = a - `XP_SEEK_TABLE_ADDR;
    pos = pk ? pm : `XP_POS_UNKNOWN;
    if (a >= `XP_SEEK_TABLE_ADDR && a <= `XP_SEEK_TABLE_LAST)
      d = half(s.seek_tab[rel[3:1]], rel[0]);
    else
    begin
      case (a)
        `XP_LAYOUT_REV_ADDR: d = `XP_LAYOUT_REV;
        `XP_MISC_CFG_ADDR: d = s.misc_cfg;
        `XP_FF_FACTOR_ADDR: d = s.ff_factor;
        `XP_BYTE_RATE_ADDR: d = rt;
        `XP_END_FILL_ADDR: d = s.end_fill;
        `XP_LAST_SEEK_ADDR: d = {13'h0, s.last_seek};
        `XP_PLAY_POS_ADDR: d = pos[15:0];
        `XP_PLAY_POS_ADDR + 16'h1: d = pos[31:16];
        `XP_RESYNC_ADDR: d = s.resync;
        // overlaid words follow the active codec
        `XP_OVL0_ADDR: d = c == xparam_pkg::CODEC_AAC ? s.sce_seen :
          c == xparam_pkg::CODEC_VORBIS ? s.ovl_a[15:0] : half(s.ovl_a, 1'b0);
        `XP_OVL1_ADDR: d = c == xparam_pkg::CODEC_AAC ? s.cpe_seen :
          half(s.ovl_a, 1'b1);
        `XP_OVL2_ADDR: d = c == xparam_pkg::CODEC_AAC ? s.lfe_seen :
          half(s.ovl_b, 1'b0);
        `XP_OVL3_ADDR: d = c == xparam_pkg::CODEC_AAC ? s.elem_choice :
          half(s.ovl_b, 1'b1);
        `XP_DRC_CUT_ADDR: d = s.drc_cut;
        `XP_DRC_LIFT_ADDR: d = s.drc_lift;
        `XP_BANDREP_ADDR: d = {12'h000, s.bandrep};
        default: d = 16'h0000;
      endcase
    end
    read_word = d;
  endfunction

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rsp.valid = win_req.rd;
    st_nxt.rsp.data = win_req.rd ?
      read_word(st_r, win_req.addr, rate, pos_known, pos_ms, active_codec) : st_r.rsp.data;

    // host writes; file_start touches none of these words
    if (wr_hit(win_req, `XP_MISC_CFG_ADDR))
      st_nxt.misc_cfg = win_req.wdata & `XP_CFG_USED_MASK;
    if (wr_hit(win_req, `XP_FF_FACTOR_ADDR))
      st_nxt.ff_factor = win_req.wdata;
    if (wr_hit(win_req, `XP_RESYNC_ADDR))
      st_nxt.resync = win_req.wdata;

    st_nxt.end_fill = fill_byte_value;

    // seek table, whole entry in one cycle so the newest one never tears
    for (int i = 0; i < 8; i++)
    begin
      if (seek_upd && seek_upd_idx == 3'(i))
        st_nxt.seek_tab[i] = seek_upd_offset;
    end
    if (seek_upd)
      st_nxt.last_seek = seek_upd_idx;

    // fast forward: every frame is decoded, only every Nth is played
    if (frame_decoded)
    begin
      if (st_r.ff_factor <= 16'h0001 || st_r.frame_cnt >= st_r.ff_factor - 16'h1)
        st_nxt.frame_cnt = 16'h0000;
      else
        st_nxt.frame_cnt = st_r.frame_cnt + 16'h1;
    end
    if (file_start)
      st_nxt.frame_cnt = 16'h0000;

    // header must be parsed before jumps; a new file wins over a done pulse
    if (header_done)
      st_nxt.seek_blocked = 1'b0;
    if (file_start)
      st_nxt.seek_blocked = 1'b1;

    // error recovery
    case (st_r.dec_state)
      xparam_pkg::DEC_RUN:
      begin
        if (stream_error)
        begin
          if (st_r.resync == 16'h0000)
            st_nxt.dec_state = xparam_pkg::DEC_GAVE_UP;
          else
          begin
            st_nxt.dec_state = xparam_pkg::DEC_RESYNC;
            st_nxt.retry_cnt = 16'h0001;
          end
        end
      end
      xparam_pkg::DEC_RESYNC:
      begin
        if (resync_found)
          st_nxt.dec_state = xparam_pkg::DEC_RUN;
        else if (stream_error)
        begin
          if (st_r.resync != `XP_RESYNC_UNLIMITED && st_r.retry_cnt >= st_r.resync)
            st_nxt.dec_state = xparam_pkg::DEC_GAVE_UP;
          else if (st_r.retry_cnt != 16'hffff)
            st_nxt.retry_cnt = st_r.retry_cnt + 16'h1;
        end
      end
      xparam_pkg::DEC_GAVE_UP:
      begin
        st_nxt.dec_state = xparam_pkg::DEC_GAVE_UP;
      end
      default:
      begin
        st_nxt.dec_state = xparam_pkg::DEC_RUN;
      end
    endcase
    if (file_start)
    begin
      st_nxt.dec_state = xparam_pkg::DEC_RUN;
      st_nxt.retry_cnt = 16'h0000;
    end

    // clock raise for the packet codec, never above the programmed maximum
    if (file_start)
      st_nxt.clk_step = 4'h0;
    else if (clk_too_slow && active_codec == xparam_pkg::CODEC_PACKET &&
             st_r.clk_step < clk_step_max)
      st_nxt.clk_step = st_r.clk_step + 4'h1;
    if (st_r.clk_step > clk_step_max)
      st_nxt.clk_step = clk_step_max;

    // overlaid codec words
    if (pkt_len_upd && active_codec == xparam_pkg::CODEC_PACKET)
    begin
      st_nxt.ovl_a = pkt_cur_len;
      st_nxt.ovl_b = pkt_hdr_len;
    end
    if (active_codec == xparam_pkg::CODEC_MIDI)
    begin
      if (midi_track_load)
        st_nxt.ovl_a = midi_track_len;
      else if (midi_byte_step && st_r.ovl_a != 32'h0)
        st_nxt.ovl_a = st_r.ovl_a - 32'h1;
    end
    if (vorbis_hdr && active_codec == xparam_pkg::CODEC_VORBIS)
      st_nxt.ovl_a = {16'h0000, vorbis_tag_found ? vorbis_tag_gain :
                      `XP_VORBIS_GAIN_DFLT};

    // element masks: a host write replaces the mask, a same-cycle sighting still lands
    if (wr_hit(win_req, `XP_OVL0_ADDR) && active_codec == xparam_pkg::CODEC_AAC)
      st_nxt.sce_seen = win_req.wdata;
    if (wr_hit(win_req, `XP_OVL1_ADDR) && active_codec == xparam_pkg::CODEC_AAC)
      st_nxt.cpe_seen = win_req.wdata;
    if (wr_hit(win_req, `XP_OVL2_ADDR) && active_codec == xparam_pkg::CODEC_AAC)
      st_nxt.lfe_seen = win_req.wdata;
    if (active_codec == xparam_pkg::CODEC_AAC)
    begin
      st_nxt.sce_seen = st_nxt.sce_seen | sce_found;
      st_nxt.cpe_seen = st_nxt.cpe_seen | cpe_found;
      st_nxt.lfe_seen = st_nxt.lfe_seen | lfe_found;
      st_nxt.bandrep = bandrep_status;
    end

    if (wr_hit(win_req, `XP_OVL3_ADDR) && active_codec == xparam_pkg::CODEC_AAC)
      st_nxt.elem_choice = win_req.wdata;
    if (wr_hit(win_req, `XP_DRC_CUT_ADDR))
      st_nxt.drc_cut = win_req.wdata;
    if (wr_hit(win_req, `XP_DRC_LIFT_ADDR))
      st_nxt.drc_lift = win_req.wdata;
    if (elem_auto_sel)
      st_nxt.elem_choice = elem_auto_value;
    // decoder start overrides any host write in the same cycle
    if (aac_start)
    begin
      st_nxt.elem_choice = 16'h0000;
      st_nxt.drc_cut = `XP_DRC_CUT_INIT;
      st_nxt.drc_lift = `XP_DRC_LIFT_INIT;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      st_r <= '0;
      st_r.resync <= `XP_RESYNC_RST;
      st_r.drc_cut <= `XP_DRC_CUT_INIT;
      st_r.drc_lift <= `XP_DRC_LIFT_INIT;
      st_r.seek_blocked <= 1'b1;
      st_r.dec_state <= xparam_pkg::DEC_RUN;
    end
    else
      st_r <= st_nxt;
  end

  // stream info low mirror of the byte rate, skipped for MPEG layers
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      info_lo_r <= 16'h0000;
      info_upd_r <= 1'b0;
    end
    else
    begin
      info_upd_r <= rate_tick && active_codec != xparam_pkg::CODEC_MPEG;
      if (rate_tick && active_codec != xparam_pkg::CODEC_MPEG)
        info_lo_r <= rate;
    end
  end

  assign win_rsp = st_r.rsp;
  // the elapsed clock steps by the skip factor so time runs proportionally fast
  assign frame_play = frame_decoded &&
    (st_r.ff_factor <= 16'h0001 || st_r.frame_cnt == 16'h0000);
  assign time_step = st_r.ff_factor <= 16'h0001 ? 16'h0001 : st_r.ff_factor;
  assign ps_mode = st_r.misc_cfg[`XP_PS_MODE_HI:`XP_PS_MODE_LO];
  assign sbr_mode = st_r.misc_cfg[`XP_SBR_MODE_HI:`XP_SBR_MODE_LO];
  assign reverb = st_r.misc_cfg[`XP_REVERB_HI:`XP_REVERB_LO];
  // no self stop at file end while resync is on; host must cancel
  assign streaming_mode = st_r.resync != 16'h0000;
  assign wav_ignore_sizes = st_r.resync != 16'h0000;
  assign seek_blocked = st_r.seek_blocked;
  assign decode_give_up = st_r.dec_state == xparam_pkg::DEC_GAVE_UP;
  assign clk_step = st_r.clk_step;
  assign elem_choice = st_r.elem_choice;
  assign drc_cut = st_r.drc_cut;
  assign drc_lift = st_r.drc_lift;
  assign stream_info_lo_upd = info_upd_r;
  assign stream_info_lo = info_lo_r;

endmodule

// ### verilog/xparam_map.svh
// offsets, field positions, reset values and timing counts of the extra
// parameter block; word addresses as seen through the ram window pointer
`ifndef XPARAM_MAP_SVH
`define XPARAM_MAP_SVH

`define XP_LAYOUT_REV_ADDR 16'h1e02
`define XP_MISC_CFG_ADDR 16'h1e03
`define XP_FF_FACTOR_ADDR 16'h1e04
`define XP_BYTE_RATE_ADDR 16'h1e05
`define XP_END_FILL_ADDR 16'h1e06
`define XP_SEEK_TABLE_ADDR 16'h1e16
`define XP_SEEK_TABLE_LAST 16'h1e25
`define XP_LAST_SEEK_ADDR 16'h1e26
`define XP_PLAY_POS_ADDR 16'h1e27
`define XP_RESYNC_ADDR 16'h1e29
`define XP_OVL0_ADDR 16'h1e2a
`define XP_OVL1_ADDR 16'h1e2b
`define XP_OVL2_ADDR 16'h1e2c
`define XP_OVL3_ADDR 16'h1e2d
`define XP_DRC_CUT_ADDR 16'h1e2e
`define XP_DRC_LIFT_ADDR 16'h1e2f
`define XP_BANDREP_ADDR 16'h1e30

`define XP_LAYOUT_REV 16'h0003
`define XP_RESYNC_RST 16'h7fff
`define XP_RESYNC_UNLIMITED 16'h7fff
`define XP_POS_UNKNOWN 32'hffffffff
`define XP_DRC_CUT_INIT 16'he000
`define XP_DRC_LIFT_INIT 16'h2000
`define XP_VORBIS_GAIN_DFLT 16'hfff4

`define XP_PS_MODE_HI 7
`define XP_PS_MODE_LO 6
`define XP_SBR_MODE_HI 5
`define XP_SBR_MODE_LO 4
`define XP_REVERB_HI 3
`define XP_REVERB_LO 0
`define XP_CFG_USED_MASK 16'h00ff

`define XP_BR_SBR_PRESENT 0
`define XP_BR_UPSAMPLE 1
`define XP_BR_PS_PRESENT 2
`define XP_BR_PS_ACTIVE 3

`define XP_REFRESH_MS 1000
`define XP_CLK_KHZ 125000
`define XP_REFRESH_CYCLES (`XP_REFRESH_MS * `XP_CLK_KHZ)

`endif

// ### verilog/xparam_pkg.sv
// types shared by the extra parameter block and its byte rate meter
package xparam_pkg;

  typedef enum logic [2:0]
  {
    CODEC_NONE = 3'b000,
    CODEC_MPEG = 3'b001,
    CODEC_AAC = 3'b010,
    CODEC_MIDI = 3'b011,
    CODEC_VORBIS = 3'b100,
    CODEC_PACKET = 3'b101,
    CODEC_WAV = 3'b110
  } codec_t;

  typedef enum logic [1:0]
  {
    DEC_RUN = 2'b00,
    DEC_RESYNC = 2'b01,
    DEC_GAVE_UP = 2'b10
  } dec_state_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } win_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } win_rsp_t;

  typedef struct packed {
    logic [31:0] cycle_cnt;
    logic [31:0] byte_cnt;
    logic [15:0] rate;
    logic tick;
  } meter_state_t;

  typedef struct packed {
    logic [15:0] misc_cfg;
    logic [15:0] ff_factor;
    logic [15:0] end_fill;
    logic [7:0][31:0] seek_tab;
    logic [2:0] last_seek;
    logic [15:0] resync;
    logic [31:0] ovl_a;
    logic [31:0] ovl_b;
    logic [15:0] sce_seen;
    logic [15:0] cpe_seen;
    logic [15:0] lfe_seen;
    logic [15:0] elem_choice;
    logic [15:0] drc_cut;
    logic [15:0] drc_lift;
    logic [3:0] bandrep;
    logic [15:0] frame_cnt;
    logic seek_blocked;
    logic [3:0] clk_step;
    logic [15:0] retry_cnt;
    dec_state_t dec_state;
    win_rsp_t rsp;
  } xstate_t;

endpackage
